/* File: fsi_defines.svh */
// fsi_defines.svh: opcodes, register bit positions, reset values and frame sizes
// assumes it is included by bare name from the fsi package and modules
`ifndef FSI_DEFINES_SVH
`define FSI_DEFINES_SVH
`define FSI_OP_STATUS_READ  8'h05
`define FSI_OP_CONFIG_READ  8'h15
`define FSI_OP_QUAD_ID_READ 8'haf
`define FSI_SR_WIP          0
`define FSI_SR_WEL          1
`define FSI_SR_BP_LSB       2
`define FSI_SR_BP_MSB       5
`define FSI_SR_QE           6
`define FSI_SR_SWD          7
`define FSI_CR_TB           3
`define FSI_CR_DC           6
`define FSI_SR_RESET        8'h00
`define FSI_CR_RESET        8'h00
`define FSI_BP_RESET        4'h0
`define FSI_OPCODE_BITS     12'd8
`define FSI_ONE_BYTE_BITS   12'd16
`define FSI_TWO_BYTE_BITS   12'd24
`define FSI_ADDR_END_BITS   12'd32
`endif

/* File: fsi_host_model.sv */
// fsi_host_model.sv: host serial controller driving chip select and clock
// assumes the bench resolves the pins; released lines sit at pull-ups
`timescale 1ns/1ps
`default_nettype none
module fsi_host_model (
  output logic            sclk_o,
  output logic            cs_n_o,
  output logic      [3:0] sio_o,
  output logic      [3:0] sio_oe_o,
  input  wire logic [3:0] pin_i
);
  initial begin
    sclk_o   = 1'b0;
    cs_n_o   = 1'b1;
    sio_o    = 4'h0;
    sio_oe_o = 4'h0;
  end
  // clock stands low outside frames, 15 ns period inside
  task automatic xfer(input logic [31:0] tx, input int ntx, input logic quad,
                      input int nrx, output logic [31:0] rx);
    int step;
    step = quad ? 4 : 1;
    rx = 32'h0;
    cs_n_o = 1'b0;
    sio_oe_o = quad ? 4'hf : 4'h1;
    for (int i = ntx - step; i >= 0; i -= step) begin
      sio_o = quad ? tx[i+:4] : {3'b000, tx[i]};
      #7.5 sclk_o = 1'b1;
      #7.5 sclk_o = 1'b0;
    end
    sio_oe_o = 4'h0;
    for (int i = 0; i < nrx; i += step) begin
      #7.5 sclk_o = 1'b1;
      rx = quad ? {rx[27:0], pin_i} : {rx[30:0], pin_i[1]};
      #7.5 sclk_o = 1'b0;
    end
    #7.5 cs_n_o = 1'b1;
  endtask
endmodule
`default_nettype wire

/* File: fsi_pkg.sv */
// fsi_pkg.sv: types shared by the status and id readout block
// assumes fsi_defines.svh sits in the same folder
`include "fsi_defines.svh"
package fsi_pkg;
  typedef enum logic [1:0] {
    FSI_IDLE  = 2'b00,
    FSI_CHECK = 2'b01,
    FSI_ARRAY = 2'b10,
    FSI_REGWR = 2'b11
  } fsi_state_e;
  typedef enum logic [1:0] {
    FSI_KIND_PROG  = 2'b00,
    FSI_KIND_ERASE = 2'b01,
    FSI_KIND_CHIP  = 2'b10
  } fsi_kind_e;
endpackage

/* File: fsi_status_id.sv */
// fsi_status_id.sv: serial flash status/config readout, id readout and
// write-enable / protection gating of program, erase and status writes.
// assumes: sclk_i is the host's serial clock, idle outside frames; pins are
// sampled on its rising edge and driven on its falling edge; chip select
// stays high for at least five clk_i cycles between frames.
// Functional notes
// R1: four-wire id read command returns maker and device id bytes
// R2: id data starts on falling edge right after opcode, msb first, no dummy
// R3: id order maker, type, density, repeating until chip select rises
// R4: status read answered at any time, also during busy operations
// R5: host should poll write-in-progress before new commands while busy
// R6: read opcodes accepted as 8 single-line or 2 four-line clocks
// R7: host sends status read opcode, device shifts status byte out
// R8: configuration register readable at any time, even while busy
// R9: status byte: disable, quad enable, protect level 3..0, latch, busy
// R10: write-in-progress reads 1 while program, erase, status write busy
// R11: write-enable command sets latch; program/erase ignored while clear
// R12: write-enable latch clears when program or erase finishes
// R13: host checks busy clear first, then write-enable latch clear
// R14: program/erase into protected area ignored and latch cleared
// R15: protect bits written only by status write, default zero
// R16: whole-chip erase only when all protect bits are zero
// R17: quad enable 0 ignores quad commands; pins act as protect and reset
// R18: quad enable 1 accepts quad, pins are data, lock and pin reset off
// R19: disable bit with protect pin low rejects status writes; default 0
// R20: status read opcode 05, configuration read 15, one byte each
// R21: config holds one-time top/bottom select, default 0, and dummy select
// R22: status byte repeats while chip select stays low
// R23: single-line byte on serial output; four-line as two nibbles
`timescale 1ns/1ps
`default_nettype none
`include "fsi_defines.svh"
module fsi_status_id
  import fsi_pkg::*;
#(
  parameter logic [7:0] MAKER_ID            = 8'h5a, // arbitrary value
  parameter logic [7:0] TYPE_ID             = 8'h3c, // arbitrary value
  parameter logic [7:0] DENSITY_ID          = 8'h0f, // arbitrary value
  parameter logic [7:0] WRITE_ENABLE_CMD_OP             = 8'h06,
  parameter logic [7:0] WRDI_OP             = 8'h04,
  parameter logic [7:0] STATUS_WRITE_CMD_OP             = 8'h01,
  parameter logic [7:0] PROG_OP             = 8'h02,
  parameter logic [7:0] SECT_ERASE_OP       = 8'h20,
  parameter logic [7:0] BLK32_ERASE_OP      = 8'h52,
  parameter logic [7:0] BLK_ERASE_OP        = 8'hd8,
  parameter logic [7:0] CHIP_ERASE_OP       = 8'hc7,
  parameter int         STATUS_WRITE_CYCLES = 40
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        sclk_i,
  input  wire logic        cs_n_i,
  input  wire logic [3:0]  sio_i,
  output logic      [3:0]  sio_o,
  output logic      [3:0]  sio_oe_o,
  input  wire logic        four_wire_mode_i,
  input  wire logic        protect_hit_i,
  input  wire logic        op_done_i,
  output logic             op_start_o,
  output logic      [1:0]  op_kind_o,
  output logic      [23:0] op_addr_o,
  output logic      [7:0]  status_o,
  output logic      [7:0]  config_o,
  output logic             hw_lock_o
);
  if (STATUS_WRITE_CYCLES < 1 || STATUS_WRITE_CYCLES > 65535) begin : g_bad_cycles
    $error("STATUS_WRITE_CYCLES out of range");
  end

  function automatic logic [7:0] pick_byte(input logic [7:0] op,
                                           input logic [1:0] ptr,
                                           input logic [15:0] snap);
    logic [7:0] b;
    b = 8'h00;
    if (op == `FSI_OP_STATUS_READ) begin
      b = snap[7:0];
    end else if (op == `FSI_OP_CONFIG_READ) begin
      b = snap[15:8];
    end else begin
      case (ptr)
        2'd0:    b = MAKER_ID;
        2'd1:    b = TYPE_ID;
        default: b = DENSITY_ID;
      endcase
    end
    return b;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // link domain: frame capture on rising sclk
  logic        active;
  logic        f_quad;
  logic [11:0] f_bits;
  logic [31:0] f_sh;
  logic [7:0]  f_op;
  logic        f_opc_done;
  logic [23:0] f_addr;
  logic [7:0]  f_data1;
  logic [7:0]  f_data2;
  logic        quad_now;
  logic [11:0] next_bits;
  logic [31:0] next_sh;
  logic [1:0]  link_meta;
  logic        mode_s;
  logic        req_s;
  logic        ack_l;
  logic [15:0] snap_l;
  logic        req;
  logic [15:0] shadow;

  // active drops asynchronously with chip select; besides it only the falling-edge read output flops are reset by it
  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      active <= 1'b0;
    end else begin
      active <= 1'b1;
    end
  end

  always_comb begin
    quad_now  = active ? f_quad : mode_s;
    next_bits = (active ? f_bits : 12'd0) + (quad_now ? 12'd4 : 12'd1);
    if (quad_now) begin
      next_sh = {(active ? f_sh[27:0] : 28'h0), sio_i}; // R6 R23
    end else begin
      next_sh = {(active ? f_sh[30:0] : 31'h0), sio_i[0]}; // R6
    end
  end

  // frame fields stay put while chip select is high, so the core reads them
  // only after its synchronised chip select has risen
  always_ff @(posedge sclk_i) begin
    f_quad <= quad_now;
    f_bits <= next_bits;
    f_sh   <= next_sh;
    if (!active) begin
      f_opc_done <= 1'b0;
    end
    if (next_bits == `FSI_OPCODE_BITS) begin
      f_op       <= next_sh[7:0];
      f_opc_done <= 1'b1;
    end
    if (next_bits == `FSI_ONE_BYTE_BITS) begin
      f_data1 <= next_sh[7:0];
    end
    if (next_bits == `FSI_TWO_BYTE_BITS) begin
      f_data2 <= next_sh[7:0];
    end
    if (next_bits == `FSI_ADDR_END_BITS) begin
      f_addr <= next_sh[23:0];
    end
  end

  // sclk stands still through reset, so a synchronous clear never lands here;
  // without this the first frame would see an unknown line mode
  always_ff @(posedge sclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      link_meta       <= 2'b00;
      {mode_s, req_s} <= 2'b00;
    end else begin
      link_meta       <= {four_wire_mode_i, req};
      {mode_s, req_s} <= link_meta;
    end
  end

  // snapshot handshake: sclk stops between frames, so only the core may own
  // the request; device reset clears this side without an sclk edge
  always_ff @(posedge sclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_l  <= 1'b0;
      snap_l <= {`FSI_CR_RESET, `FSI_SR_RESET};
    end else if (req_s != ack_l) begin
      snap_l <= shadow; // R4 R8
      ack_l  <= req_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // link domain: read data driven on falling sclk
  logic       rd_cmd;
  logic [7:0] out_sh;
  logic [1:0] id_ptr;
  logic [7:0] new_byte;

  always_comb begin
    rd_cmd = f_opc_done &&
             (f_op == `FSI_OP_STATUS_READ || f_op == `FSI_OP_CONFIG_READ ||
              (f_op == `FSI_OP_QUAD_ID_READ && f_quad)) && // R1 R20
             (!f_quad || snap_l[`FSI_SR_QE]); // R17
    new_byte = pick_byte(f_op, id_ptr, snap_l); // R22
  end

  always_ff @(negedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      sio_o    <= 4'h0;
      sio_oe_o <= 4'h0;
      out_sh   <= 8'h00;
      id_ptr   <= 2'd0;
    end else if (rd_cmd) begin // R2 R7
      if (f_bits[2:0] == 3'd0) begin
        out_sh <= new_byte;
        id_ptr <= (id_ptr == 2'd2) ? 2'd0 : id_ptr + 2'd1; // R3
        if (f_quad) begin
          sio_o    <= new_byte[7:4]; // R23
          sio_oe_o <= 4'hf;
        end else begin
          sio_o    <= {2'b00, new_byte[7], 1'b0}; // R23
          sio_oe_o <= 4'h2;
        end
      end else if (f_quad) begin
        sio_o <= out_sh[3:0];
      end else begin
        sio_o <= {2'b00, out_sh[3'd7 - f_bits[2:0]], 1'b0};
      end
    end else begin
      sio_o    <= 4'h0;
      sio_oe_o <= 4'h0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // core domain: pin synchronisers and frame end
  logic       cs_s;
  logic       wp_s;
  logic       rpin_s;
  logic       ack_s;
  logic       cs_d;
  logic       frame_end;
  logic       frame_ok;
  logic       pin_rst;
  logic       lock_now;
  fsi_state_e state;
  logic [15:0] timer;
  logic        write_in_progress;
  logic        write_enable_latch;
  logic        swd;
  logic        qe;
  logic [3:0]  bp;
  logic        tb;
  logic        dc;

  fsi_sync2 #(
    .WIDTH     (4),
    .RESET_VAL (32'he)
  ) u_sync_core (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .d_i     ({cs_n_i, sio_i[2], sio_i[3], ack_l}),
    .q_o     ({cs_s, wp_s, rpin_s, ack_s})
  );

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cs_d <= 1'b1;
    end else begin
      cs_d <= cs_s;
    end
  end

  always_comb begin
    frame_end = cs_s && !cs_d;
    frame_ok  = !f_quad || qe; // R17 R18
    pin_rst   = !qe && !rpin_s; // R17 R18
    lock_now  = swd && !wp_s && !qe; // R19 R18
  end

  //////////////////////////////////////////////////////////////////////////
  // core domain: command decode
  logic ev_write_enable_cmd;
  logic ev_wrdi;
  logic ev_status_write_cmd;
  logic is_prog;
  logic is_erase;
  logic is_chip;
  logic ev_pe;
  logic ev_chip_refuse;
  logic wr_done;

  always_comb begin
    logic take;
    take     = frame_end && frame_ok && f_opc_done && state == FSI_IDLE;
    is_prog  = f_op == PROG_OP && f_bits >= `FSI_ADDR_END_BITS && f_bits[2:0] == 3'd0;
    is_erase = (f_op == SECT_ERASE_OP || f_op == BLK32_ERASE_OP ||
                f_op == BLK_ERASE_OP) && f_bits == `FSI_ADDR_END_BITS;
    is_chip  = f_op == CHIP_ERASE_OP && f_bits == `FSI_OPCODE_BITS;
    ev_write_enable_cmd  = take && f_op == WRITE_ENABLE_CMD_OP && f_bits == `FSI_OPCODE_BITS; // R11
    ev_wrdi  = take && f_op == WRDI_OP && f_bits == `FSI_OPCODE_BITS;
    ev_status_write_cmd  = take && write_enable_latch && !lock_now && f_op == STATUS_WRITE_CMD_OP && // R19 R15
               (f_bits == `FSI_ONE_BYTE_BITS || f_bits == `FSI_TWO_BYTE_BITS);
    ev_pe    = take && write_enable_latch && (is_prog || is_erase || (is_chip && bp == 4'h0)); // R11 R16
    ev_chip_refuse = take && write_enable_latch && is_chip && bp != 4'h0; // R16
    wr_done  = state == FSI_REGWR && timer == 16'd1;
  end

  //////////////////////////////////////////////////////////////////////////
  // core domain: busy sequencing
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || pin_rst) begin
      state      <= FSI_IDLE;
      write_in_progress        <= 1'b0;
      timer      <= 16'd0;
      op_start_o <= 1'b0;
      op_kind_o  <= FSI_KIND_PROG;
      op_addr_o  <= 24'h0;
    end else begin
      op_start_o <= 1'b0;
      case (state)
        FSI_IDLE: begin
          if (ev_pe) begin
            state     <= FSI_CHECK;
            op_addr_o <= is_chip ? 24'h0 : f_addr;
            op_kind_o <= is_prog ? FSI_KIND_PROG : (is_chip ? FSI_KIND_CHIP : FSI_KIND_ERASE);
          end else if (ev_status_write_cmd) begin
            state <= FSI_REGWR;
            write_in_progress   <= 1'b1; // R10
            timer <= 16'(STATUS_WRITE_CYCLES);
          end
        end
        FSI_CHECK: begin
          // protect lookup is one cycle behind the registered address
          if (protect_hit_i && op_kind_o != FSI_KIND_CHIP) begin
            state <= FSI_IDLE; // R14
          end else begin
            state      <= FSI_ARRAY;
            write_in_progress        <= 1'b1; // R10
            op_start_o <= 1'b1;
          end
        end
        FSI_ARRAY: begin
          if (op_done_i) begin
            state <= FSI_IDLE;
            write_in_progress   <= 1'b0; // R10
          end
        end
        FSI_REGWR: begin
          timer <= timer - 16'd1;
          if (wr_done) begin
            state <= FSI_IDLE;
            write_in_progress   <= 1'b0; // R10
          end
        end
        default: begin
          state <= FSI_IDLE;
          write_in_progress   <= 1'b0;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // core domain: write-enable latch
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || pin_rst) begin
      write_enable_latch <= 1'b0;
    end else if (ev_write_enable_cmd) begin
      write_enable_latch <= 1'b1; // R11
    end else if (ev_wrdi || ev_chip_refuse || wr_done) begin
      write_enable_latch <= 1'b0; // R16
    end else if (state == FSI_CHECK && protect_hit_i && op_kind_o != FSI_KIND_CHIP) begin
      write_enable_latch <= 1'b0; // R14
    end else if (state == FSI_ARRAY && op_done_i) begin
      write_enable_latch <= 1'b0; // R12
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // core domain: stored bits; flops stand in for the non-volatile cells
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      swd <= 1'b0; // R19
      qe  <= 1'b0; // R17
      bp  <= `FSI_BP_RESET; // R15
      tb  <= 1'b0; // R21
    end else if (ev_status_write_cmd) begin
      swd <= f_data1[`FSI_SR_SWD];
      qe  <= f_data1[`FSI_SR_QE];
      bp  <= f_data1[`FSI_SR_BP_MSB:`FSI_SR_BP_LSB]; // R15
      if (f_bits == `FSI_TWO_BYTE_BITS) begin
        tb <= tb | f_data2[`FSI_CR_TB]; // R21
      end
    end
  end

  // volatile dummy select is lost on any reset
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || pin_rst) begin
      dc <= 1'b0;
    end else if (ev_status_write_cmd && f_bits == `FSI_TWO_BYTE_BITS) begin
      dc <= f_data2[`FSI_CR_DC]; // R21
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      status_o  <= `FSI_SR_RESET;
      config_o  <= `FSI_CR_RESET;
      hw_lock_o <= 1'b0;
    end else begin
      status_o  <= {swd, qe, bp, write_enable_latch, write_in_progress}; // R9
      config_o  <= {1'b0, dc, 2'b00, tb, 3'b000}; // R21
      hw_lock_o <= lock_now; // R18
    end
  end

  // one word in flight at a time; a change while busy goes in the next round
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      req    <= 1'b0;
      shadow <= {`FSI_CR_RESET, `FSI_SR_RESET};
    end else if (req == ack_s && shadow != {config_o, status_o}) begin
      shadow <= {config_o, status_o}; // R4 R8
      req    <= ~req;
    end
  end
endmodule
`default_nettype wire

/* File: fsi_status_id_bench.sv */
// fsi_status_id_bench.sv: self-checking bench for the readout block
// assumes fsi_status_id, its checker and fsi_host_model are compiled first
`timescale 1ns/1ps
`default_nettype none
module fsi_status_id_bench;
  localparam logic [7:0] MAKER = 8'h3a; // arbitrary value
  localparam logic [7:0] TYPE  = 8'h7e; // arbitrary value
  localparam logic [7:0] DENS  = 8'h11; // arbitrary value
  logic        clk_i, rst_n_i, sclk_i, cs_n_i, four_wire_mode_i, protect_hit_i;
  logic        op_done_i, op_start_o, hw_lock_o, wp_n, qm;
  logic [3:0]  sio_i, sio_o, sio_oe_o, h_sio, h_oe;
  logic [1:0]  op_kind_o, st_kind;
  logic [23:0] op_addr_o, st_addr;
  logic [7:0]  status_o, config_o;
  logic [31:0] rx;
  int          num_errors, n_checks, n_start;
  // device wins over host; idle lines pulled up, line 2 follows the protect pin
  assign sio_i = (sio_oe_o & sio_o) | (~sio_oe_o & h_oe & h_sio)
               | (~sio_oe_o & ~h_oe & {1'b1, wp_n, 2'b11});
  fsi_status_id #(.MAKER_ID(MAKER), .TYPE_ID(TYPE), .DENSITY_ID(DENS),
    .STATUS_WRITE_CYCLES(4)) dut (.clk_i, .rst_n_i, .sclk_i, .cs_n_i, .sio_i,
    .sio_o, .sio_oe_o, .four_wire_mode_i, .protect_hit_i, .op_done_i, .op_start_o,
    .op_kind_o, .op_addr_o, .status_o, .config_o, .hw_lock_o);
  fsi_host_model host (.sclk_o(sclk_i), .cs_n_o(cs_n_i), .sio_o(h_sio),
    .sio_oe_o(h_oe), .pin_i(sio_i));
  ////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  always @(negedge clk_i) begin
    if (op_start_o === 1'b1) begin
      n_start++;
      st_kind = op_kind_o;
      st_addr = op_addr_o;
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  // gap well above the minimum deselect time, lets the command settle
  task automatic frame(input logic [31:0] tx, input int ntx, input int nrx);
    host.xfer(tx, ntx, qm, nrx, rx);
    repeat (20) @(negedge clk_i);
  endtask
  // first byte may be a stale snapshot, so only the repeats are compared
  task automatic rdreg(input string n, input logic [7:0] op, input logic [7:0] e);
    frame({24'h0, op}, 8, 24);
    chk(n, {16'h0, e, e}, {16'h0, rx[15:0]});
  endtask
  task automatic wen(input logic [31:0] tx, input int n);
    frame(32'h06, 8, 0);
    frame(tx, n, 0);
  endtask
  task automatic done_pulse();
    @(negedge clk_i) op_done_i = 1'b1;
    @(negedge clk_i) op_done_i = 1'b0;
    repeat (20) @(negedge clk_i);
  endtask
  task automatic test_done();
    $display("checks %0d, mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    #100000;
    num_errors++;
    test_done();
  end
  initial begin
    rst_n_i = 1'b0;
    four_wire_mode_i = 1'b0;
    protect_hit_i = 1'b0;
    op_done_i = 1'b0;
    wp_n = 1'b1;
    qm = 1'b0;
    repeat (8) @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (4) @(negedge clk_i);
    chk("status_o", 32'h0, {24'h0, status_o});
    chk("config_o", 32'h0, {24'h0, config_o});
    rdreg("status", 8'h05, 8'h00);
    rdreg("config", 8'h15, 8'h00);
    frame(32'h0212_3456, 32, 0);
    chk("starts", 32'd0, n_start);
    frame(32'h06, 8, 0);
    rdreg("status", 8'h05, 8'h02);
    frame(32'h0212_3456, 32, 0);
    chk("starts", 32'd1, n_start);
    chk("op_addr_o", 32'h0012_3456, {8'h0, st_addr});
    rdreg("status busy", 8'h05, 8'h03);
    rdreg("config busy", 8'h15, 8'h00);
    done_pulse();
    rdreg("status done", 8'h05, 8'h00);
    wen(32'h0104, 16);
    rdreg("status", 8'h05, 8'h04);
    wen(32'hc7, 8);
    rdreg("status", 8'h05, 8'h04);
    protect_hit_i = 1'b1;
    wen(32'h2000_1000, 32);
    rdreg("status", 8'h05, 8'h04);
    chk("starts", 32'd1, n_start);
    protect_hit_i = 1'b0;
    wen(32'h2000_1000, 32);
    chk("op_kind_o", 32'h1_0002, {14'h0, st_kind, 16'(n_start)});
    done_pulse();
    wen(32'h0001_0048, 24);
    rdreg("config written", 8'h15, 8'h48);
    chk("config_o", 32'h48, {24'h0, config_o});
    wen(32'h0140, 16);
    four_wire_mode_i = 1'b1;
    frame(32'h0, 8, 0);
    qm = 1'b1;
    rdreg("quad status", 8'h05, 8'h40);
    rdreg("quad config", 8'h15, 8'h48);
    frame(32'haf, 8, 32);
    chk("id", {MAKER, TYPE, DENS, MAKER}, rx);
    wen(32'hc7, 8);
    chk("chip erase", 32'h8000_0003, {st_kind, st_addr[13:0], 16'(n_start)});
    done_pulse();
    four_wire_mode_i = 1'b0;
    frame(32'h0, 8, 0);
    qm = 1'b0;
    wen(32'h0180, 16);
    wp_n = 1'b0;
    wen(32'h0100, 16);
    chk("status_o", 32'h20, {26'h0, status_o[7:2]});
    chk("hw_lock_o", 32'h1, {31'h0, hw_lock_o});
    wp_n = 1'b1;
    four_wire_mode_i = 1'b1;
    frame(32'h0, 8, 0);
    qm = 1'b1;
    frame(32'h05, 8, 8);
    chk("quad refused", 32'hff, rx);
    test_done();
  end
endmodule
`default_nettype wire

/* File: fsi_status_id_properties.sv */
// fsi_status_id_properties.sv: port-level checks for the readout block
// assumes it is bound onto fsi_status_id and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module fsi_status_id_properties #(
  parameter int STATUS_WRITE_CYCLES = 40
) (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        sclk_i,
  input wire logic        cs_n_i,
  input wire logic [3:0]  sio_i,
  input wire logic [3:0]  sio_o,
  input wire logic [3:0]  sio_oe_o,
  input wire logic        four_wire_mode_i,
  input wire logic        protect_hit_i,
  input wire logic        op_done_i,
  input wire logic        op_start_o,
  input wire logic [1:0]  op_kind_o,
  input wire logic [23:0] op_addr_o,
  input wire logic [7:0]  status_o,
  input wire logic [7:0]  config_o,
  input wire logic        hw_lock_o
);
  ////////////////////////////////////////
  sequence s_wip_up;
    ##[1:2] status_o[0];
  endsequence
  sequence s_cleared;
    ##[1:3] (status_o[1:0] == 2'b00);
  endsequence
  ////////////////////////////////////////
  AST_OE_IDLE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cs_n_i |-> sio_oe_o == 4'h0) else $error("pins driven while deselected");
  AST_OE_CODE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    sio_oe_o inside {4'h0, 4'h2, 4'hf}) else $error("odd output enable");
  AST_START_WEL: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    op_start_o |-> status_o[1]) else $error("start without latch");
  AST_START_PULSE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    op_start_o |=> !op_start_o) else $error("start longer than a cycle");
  AST_START_BUSY: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    op_start_o |-> s_wip_up) else $error("busy flag not raised");
  AST_CHIP_BP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    op_start_o && op_kind_o == 2'd2 |-> status_o[5:2] == 4'h0 && op_addr_o == 24'h0)
    else $error("chip erase with protect bits");
  AST_PROTECT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    op_start_o |-> !$past(protect_hit_i)) else $error("start into protected area");
  AST_DONE_CLEAR: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    op_done_i && status_o[0] |-> s_cleared) else $error("done did not clear");
  AST_HW_LOCK: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (status_o[7] && !status_o[6] && !sio_i[2]) [*6] |-> hw_lock_o)
    else $error("lock not entered");
  AST_QUAD_OUT: assert property (@(posedge sclk_i) disable iff (!rst_n_i)
    sio_oe_o == 4'hf |-> status_o[6]) else $error("four-line output without quad");
endmodule
bind fsi_status_id fsi_status_id_properties #(
  .STATUS_WRITE_CYCLES(STATUS_WRITE_CYCLES)
) u_props (.clk_i, .rst_n_i, .sclk_i, .cs_n_i, .sio_i, .sio_o, .sio_oe_o,
  .four_wire_mode_i, .protect_hit_i, .op_done_i, .op_start_o, .op_kind_o,
  .op_addr_o, .status_o, .config_o, .hw_lock_o);
`default_nettype wire

/* File: fsi_sync2.sv */
// fsi_sync2.sv: two flip-flop level synchroniser, parameterised width
// assumes each bit is an independent level; words must not pass here
`timescale 1ns/1ps
`default_nettype none
module fsi_sync2 #(
  parameter int          WIDTH     = 1,
  parameter logic [31:0] RESET_VAL = 32'h0
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta <= RESET_VAL[WIDTH-1:0];
      q_o  <= RESET_VAL[WIDTH-1:0];
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule
`default_nettype wire
